/* File: hw/vaf_defines.svh */
`ifndef VAF_DEFINES_SVH
`define VAF_DEFINES_SVH
`define VAF_REG_CROP_START_HI 8'h11
`define VAF_REG_CROP_START_LO 8'h12
`define VAF_REG_CROP_STOP_HI 8'h13
`define VAF_REG_CROP_STOP_LO 8'h14
`define VAF_REG_VB_START 8'h18
`define VAF_REG_VB_STOP 8'h19
`define VAF_REG_CTRL 8'h1a
`define VAF_REG_EDGE_HI 8'h1b
`define VAF_REG_EDGE_LO 8'h1c
`define VAF_REG_LEVEL_LO 8'h1d
`define VAF_REG_LEVEL_HI 8'h1e
`define VAF_REG_FIFO_DATA 8'hb0
`define VAF_CTRL_BT656 0
`define VAF_CTRL_RAW 1
`define VAF_CTRL_STD625 2
`define VAF_CTRL_SEL3 3
`define VAF_CTRL_SEL4 4
`define VAF_CTRL_SEL5 5
`define VAF_CTRL_GPVAL 6
`define VAF_CTRL_ANC_EN 7
`define VAF_RST_CROP_START_HI 8'h00
`define VAF_RST_CROP_START_LO 8'h8a
`define VAF_RST_CROP_STOP_HI 8'h03
`define VAF_RST_CROP_STOP_LO 8'h5a
`define VAF_RST_VB_START 8'h00
`define VAF_RST_VB_STOP 8'h14
`define VAF_RST_CTRL 8'h81
`define VAF_RST_EDGE 8'h00
`define VAF_PRE0 8'h00
`define VAF_PRE1 8'hff
`define VAF_FILL 8'h80
`define VAF_DID_F1_VBI 8'h91
`define VAF_DID_F2_VBI 8'h55
`define VAF_DID_F1_LATE 8'h53
`define VAF_DID_F2_LATE 8'h97
`define VAF_LATE_LINE 10'h018
`define VAF_FIRST_LINE 10'h006
`define VAF_LAST_LINE 10'h01b
`define VAF_TTX_MAX_MODE 4'h5
`define VAF_HDR_LEN 7'h08
`define VAF_LEN_ROUND 7'h0c
`define VAF_LEN_MASK 7'h7c
`define VAF_PAY_MAX 6'h34
`define VAF_FIFO_DEPTH 10'h200
`define VAF_LEN_525 10'h35a
`define VAF_LEN_625 10'h360
`define VAF_ACTIVE 10'h2d0
`define VAF_LINES_525 10'h20d
`define VAF_LINES_625 10'h271
`define VAF_F2_525 10'h107
`define VAF_F2_625 10'h139
`define VAF_HSYNC_LEN 10'h040
`define VAF_VSYNC_LINES 10'h003
`define VAF_EARLY 10'h004
`define VAF_CODE_LEN 10'h004
`define VAF_BLANK_Y 8'h10
`define VAF_BLANK_C 8'h80
`endif

/* File: hw/vaf_formatter.sv */
// Behaviour
// R01: BT.656 mode carries sliced data as ancillary packets
// R02: packet sent in next line's horizontal blanking
// R03: 512-byte fifo holds same packet layout
// R04: preamble, ids, count, line ids, payload, checksum, fill
// R05: bit6 even parity, bit7 inverse; 010 in PACKET_TYPE_ID
// R06: PACKET_TYPE_ID 91h/55h VBI, 53h/97h from line 24
// R07: secondary id holds the line's mode
// R08: count byte gives dwords from byte 8 on
// R09: line number low byte, then high bits and flags
// R10: checksum is six-bit sum plus parity bits
// R11: fill 80h bytes up to multiple of four
// R12: teletext puts sync pattern at byte 8
// R13: raw mode sends A/D samples in active area
// R14: 8-bit bus, 4:2:2 discrete or BT.656 embedded
// R15: 858 or 864 clocks per line, 720 active
// R16: six sync outputs, three with selectable meaning
// R17: sync edges at a programmed pixel count
// R18: BT.656 active video rises four clocks earlier
// R19: active video starts at programmed start pixel
// R20: active video ends at programmed stop pixel
// R21: vertical blank window suppresses active video
// R22: teletext results reach software only via fifo
// R23: only lines 6 to 27 produce packets
// R24: packet written to fifo only if it fits
`include "vaf_defines.svh"
`default_nettype none
module vaf_formatter
  import vaf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic sliceStart,
  input wire vaf_slice_info_s sliceInfo,
  input wire logic sliceValid,
  input wire logic [7:0] sliceByte,
  input wire logic sliceEnd,
  input wire logic sclk,
  input wire logic [7:0] videoIn,
  input wire logic [7:0] adSample,
  input wire logic verticalLockIndicator,
  input wire logic horizontalLockIndicator,
  output logic [7:0] pixelOut,
  output logic vsyncOut,
  output logic hsyncOut,
  output logic activeVideoIndicator,
  output logic fieldOrVlockPin,
  output logic gpOrVblankPin,
  output logic palOrHlockPin
);

  function automatic logic [7:0] par6(input logic [5:0] d);
    logic p;
    p = ^d;
    par6 = {~p, p, d}; // R05
  endfunction : par6

  // register file, clk domain
  logic [7:0] cropStartHi, cropStartLo, cropStopHi, cropStopLo;
  logic [7:0] vbStart, vbStop, ctrl, edgeHi, edgeLo;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cropStartHi <= `VAF_RST_CROP_START_HI;
      cropStartLo <= `VAF_RST_CROP_START_LO;
      cropStopHi <= `VAF_RST_CROP_STOP_HI;
      cropStopLo <= `VAF_RST_CROP_STOP_LO;
      vbStart <= `VAF_RST_VB_START;
      vbStop <= `VAF_RST_VB_STOP;
      ctrl <= `VAF_RST_CTRL;
      edgeHi <= `VAF_RST_EDGE;
      edgeLo <= `VAF_RST_EDGE;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `VAF_REG_CROP_START_HI: cropStartHi <= regWrData;
        `VAF_REG_CROP_START_LO: cropStartLo <= regWrData;
        `VAF_REG_CROP_STOP_HI: cropStopHi <= regWrData;
        `VAF_REG_CROP_STOP_LO: cropStopLo <= regWrData;
        `VAF_REG_VB_START: vbStart <= regWrData;
        `VAF_REG_VB_STOP: vbStop <= regWrData;
        `VAF_REG_CTRL: ctrl <= regWrData;
        `VAF_REG_EDGE_HI: edgeHi <= regWrData;
        `VAF_REG_EDGE_LO: edgeLo <= regWrData;
        default: ;
      endcase
    end
  end

  vaf_cfg_s cfgLive;
  assign cfgLive = {cropStartHi[1:0], cropStartLo, cropStopHi[1:0], cropStopLo,
                    vbStart, vbStop, edgeHi[1:0], edgeLo, ctrl};

  // config handshake to the pixel domain; snapshot held until acknowledged
  logic cfgDirty, cfgReq, cfgAckS1, cfgAckS2;
  // pixel-domain handshake returns, read back here through two flops
  logic cfgSeen, pktSeen;
  vaf_cfg_s cfgHold;
  wire cfgLaunch = cfgDirty && (cfgReq == cfgAckS2);
  wire cfgWrite = regWrite && (regAddr != `VAF_REG_FIFO_DATA);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgDirty <= 1'b1;
      cfgReq <= 1'b0;
      cfgHold <= '0;
      cfgAckS1 <= 1'b0;
      cfgAckS2 <= 1'b0;
    end
    else
    begin
      // a write landing with the launch stays pending
      cfgDirty <= cfgWrite || (cfgDirty && !cfgLaunch);
      if (cfgLaunch)
      begin
        cfgHold <= cfgLive;
        cfgReq <= ~cfgReq;
      end
      cfgAckS1 <= cfgSeen;
      cfgAckS2 <= cfgAckS1;
    end
  end

  // packet builder
  vaf_build_e state;
  vaf_slice_info_s info;
  logic [7:0] payload [0:51];
  logic [5:0] payLen, csum;
  logic [6:0] copyIdx;
  logic copyFits, pktReq, pktAckS1, pktAckS2;
  logic [9:0] level;

  wire lineOk = sliceInfo.lineNum >= `VAF_FIRST_LINE
             && sliceInfo.lineNum <= `VAF_LAST_LINE; // R23
  wire isTtx = sliceInfo.lineMode <= `VAF_TTX_MAX_MODE;
  wire late = info.lineNum >= `VAF_LATE_LINE;
  wire [7:0] didByte = info.field ? (late ? `VAF_DID_F2_LATE : `VAF_DID_F2_VBI)
                                  : (late ? `VAF_DID_F1_LATE : `VAF_DID_F1_VBI); // R06
  wire [7:0] sdidByte = par6({2'h0, info.lineMode}); // R07
  wire [7:0] idid1Byte = {3'h0, info.edcError, info.match1, info.match2,
                          info.lineNum[9:8]}; // R09
  wire [6:0] pktLen = (7'(payLen) + `VAF_LEN_ROUND) & `VAF_LEN_MASK; // R11
  wire [7:0] nnByte = par6(6'((pktLen - `VAF_HDR_LEN) >> 2)); // R08
  wire [7:0] csByte = par6(csum + nnByte[5:0]); // R10
  wire [6:0] csIdx = `VAF_HDR_LEN + 7'(payLen);
  wire [5:0] startSum = 6'(didByte) + 6'(sdidByte) + 6'(info.lineNum[7:0]) + 6'(idid1Byte);
  wire [5:0] fifoIdxLast = 6'(pktLen - 7'h01);

  function automatic logic [7:0] pktByte(input logic [6:0] idx);
    logic [5:0] payIdx;
    payIdx = 6'(idx - `VAF_HDR_LEN);
    case (idx) // R04
      7'h00: pktByte = `VAF_PRE0;
      7'h01: pktByte = `VAF_PRE1;
      7'h02: pktByte = `VAF_PRE1;
      7'h03: pktByte = didByte;
      7'h04: pktByte = sdidByte;
      7'h05: pktByte = nnByte;
      7'h06: pktByte = info.lineNum[7:0];
      7'h07: pktByte = idid1Byte;
      default:
        if (idx < csIdx)
          pktByte = payload[payIdx];
        else if (idx == csIdx)
          pktByte = csByte;
        else
          pktByte = `VAF_FILL; // R11
    endcase
  endfunction : pktByte

  wire [7:0] copyByte = pktByte(copyIdx);
  wire [9:0] fifoFree = `VAF_FIFO_DEPTH - level;
  wire ancOn = ctrl[`VAF_CTRL_BT656] && ctrl[`VAF_CTRL_ANC_EN]; // R01

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= B_IDLE;
      info <= '0;
      payLen <= 6'h00;
      csum <= 6'h00;
      copyIdx <= 7'h00;
      copyFits <= 1'b0;
      pktReq <= 1'b0;
    end
    else
    begin
      case (state)
        B_IDLE:
          if (sliceStart && lineOk) // R23
          begin
            info <= sliceInfo;
            payLen <= isTtx ? 6'h01 : 6'h00; // R12
            csum <= isTtx ? 6'(sliceInfo.syncPattern) : 6'h00;
            state <= B_DATA;
          end
        B_DATA:
          if (sliceEnd)
          begin
            csum <= csum + startSum; // R10
            copyIdx <= 7'h00;
            copyFits <= {3'h0, pktLen} <= fifoFree; // R24
            state <= B_COPY;
            if (ancOn)
              pktReq <= ~pktReq; // R02
          end
          else if (sliceValid && payLen < `VAF_PAY_MAX)
          begin
            payLen <= payLen + 6'h01;
            csum <= csum + sliceByte[5:0]; // R10
          end
        B_COPY:
        begin
          copyIdx <= copyIdx + 7'h01;
          if (copyIdx[5:0] == fifoIdxLast)
            state <= B_WAIT;
        end
        B_WAIT:
          if (pktReq == pktAckS2)
            state <= B_IDLE;
        default: state <= B_IDLE;
      endcase
    end
  end

  // payload store; sync pattern sits in slot 0 for teletext
  always_ff @(posedge clk)
  begin
    if (state == B_IDLE)
      payload[0] <= sliceInfo.syncPattern; // R12
    else if (state == B_DATA && sliceValid && !sliceEnd && payLen < `VAF_PAY_MAX)
      payload[payLen] <= sliceByte;
  end

  // fifo: every line mode, teletext included, reaches software only here
  logic [7:0] fifoMem [0:511];
  logic [8:0] wrPtr, rdPtr;
  wire fifoWr = (state == B_COPY) && copyFits; // R03 R22 R24
  wire fifoRd = regRead && (regAddr == `VAF_REG_FIFO_DATA) && (level != 10'h000);

  always_ff @(posedge clk)
  begin
    if (fifoWr)
      fifoMem[wrPtr] <= copyByte; // R03
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= 9'h000;
      rdPtr <= 9'h000;
      level <= 10'h000;
      pktAckS1 <= 1'b0;
      pktAckS2 <= 1'b0;
    end
    else
    begin
      wrPtr <= wrPtr + {8'h00, fifoWr};
      rdPtr <= rdPtr + {8'h00, fifoRd};
      level <= level + {9'h000, fifoWr} - {9'h000, fifoRd};
      pktAckS1 <= pktSeen;
      pktAckS2 <= pktAckS1;
    end
  end

  logic [7:0] next_regRdData;
  always_comb
  begin
    case (regAddr)
      `VAF_REG_CROP_START_HI: next_regRdData = cropStartHi;
      `VAF_REG_CROP_START_LO: next_regRdData = cropStartLo;
      `VAF_REG_CROP_STOP_HI: next_regRdData = cropStopHi;
      `VAF_REG_CROP_STOP_LO: next_regRdData = cropStopLo;
      `VAF_REG_VB_START: next_regRdData = vbStart;
      `VAF_REG_VB_STOP: next_regRdData = vbStop;
      `VAF_REG_CTRL: next_regRdData = ctrl;
      `VAF_REG_EDGE_HI: next_regRdData = edgeHi;
      `VAF_REG_EDGE_LO: next_regRdData = edgeLo;
      `VAF_REG_LEVEL_LO: next_regRdData = level[7:0];
      `VAF_REG_LEVEL_HI: next_regRdData = {6'h00, level[9:8]};
      `VAF_REG_FIFO_DATA: next_regRdData = fifoRd ? fifoMem[rdPtr] : 8'h00;
      default: next_regRdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= 8'h00;
    else if (regRead)
      regRdData <= next_regRdData;
  end

  // pixel domain
  logic cfgReqS1, cfgReqS2;
  logic pktReqS1, pktReqS2;
  vaf_cfg_s pcfg;
  logic [9:0] pix, line;
  logic [6:0] linkIdx;
  logic sending, vsyncR, fieldR, vblankR, palR;

  wire bt656 = pcfg.ctrl[`VAF_CTRL_BT656];
  wire std625 = pcfg.ctrl[`VAF_CTRL_STD625];
  wire [9:0] lineLen = std625 ? `VAF_LEN_625 : `VAF_LEN_525; // R15
  wire [9:0] lineCnt = std625 ? `VAF_LINES_625 : `VAF_LINES_525;
  wire [9:0] f2Line = std625 ? `VAF_F2_625 : `VAF_F2_525;
  wire [9:0] activeStart = lineLen - `VAF_ACTIVE; // R15
  wire [9:0] savAt = activeStart - `VAF_CODE_LEN;
  wire lineEnd = pix == lineLen - 10'h001;
  wire field = line >= f2Line;
  wire [9:0] fieldLine = field ? line - f2Line : line;
  wire inActive = pix >= activeStart;
  wire inEav = pix < `VAF_CODE_LEN;
  wire inSav = pix >= savAt && !inActive;
  wire [1:0] codePos = inEav ? pix[1:0] : 2'(pix - savAt);
  wire hBit = inEav;
  wire [7:0] status = {1'b1, fieldR, vblankR, hBit, vblankR ^ hBit, fieldR ^ hBit,
                       fieldR ^ vblankR, fieldR ^ vblankR ^ hBit};
  wire [7:0] codeByte = codePos == 2'h3 ? status
                      : (codePos == 2'h0 ? `VAF_PRE1 : `VAF_PRE0);
  wire pktNew = pktReqS2 != pktSeen;
  wire [7:0] linkByte = pktByte(linkIdx); // held stable by the handshake
  wire [9:0] avidRise = (bt656 && pcfg.cropStart >= `VAF_EARLY)
                      ? pcfg.cropStart - `VAF_EARLY : pcfg.cropStart; // R18 R19
  wire avidOn = pix >= avidRise && pix < pcfg.cropStop && !vblankR; // R20 R21
  wire edgeHit = pix == pcfg.syncEdge;
  wire vbWin = fieldLine >= {2'h0, pcfg.vbStart} && fieldLine < {2'h0, pcfg.vbStop};

  logic [7:0] next_pixelOut;
  always_comb
  begin
    if (pcfg.ctrl[`VAF_CTRL_RAW] && inActive)
      next_pixelOut = adSample; // R13
    else if (bt656 && (inEav || inSav))
      next_pixelOut = codeByte; // R14
    else if (bt656 && sending)
      next_pixelOut = linkByte; // R01
    else if (inActive && !vblankR)
      next_pixelOut = videoIn; // R14
    else
      next_pixelOut = pix[0] ? `VAF_BLANK_Y : `VAF_BLANK_C;
  end

  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgReqS1 <= 1'b0;
      cfgReqS2 <= 1'b0;
      cfgSeen <= 1'b0;
      pcfg <= '0;
      pktReqS1 <= 1'b0;
      pktReqS2 <= 1'b0;
      pktSeen <= 1'b0;
    end
    else
    begin
      cfgReqS1 <= cfgReq;
      cfgReqS2 <= cfgReqS1;
      if (cfgReqS2 != cfgSeen)
      begin
        pcfg <= cfgHold;
        cfgSeen <= cfgReqS2;
      end
      pktReqS1 <= pktReq;
      pktReqS2 <= pktReqS1;
      if (sending && linkIdx[5:0] == fifoIdxLast)
        pktSeen <= pktReqS2;
    end
  end

  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pix <= 10'h000;
      line <= 10'h000;
      sending <= 1'b0;
      linkIdx <= 7'h00;
    end
    else
    begin
      pix <= lineEnd ? 10'h000 : pix + 10'h001;
      if (lineEnd)
        line <= (line == lineCnt - 10'h001) ? 10'h000 : line + 10'h001; // R15
      if (!sending && pktNew && pix == `VAF_CODE_LEN) // R02
      begin
        sending <= 1'b1;
        linkIdx <= 7'h00;
      end
      else if (sending)
      begin
        linkIdx <= linkIdx + 7'h01;
        if (linkIdx[5:0] == fifoIdxLast)
          sending <= 1'b0;
      end
    end
  end

  // line-rate signals change only at the programmed pixel count
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vsyncR <= 1'b0;
      fieldR <= 1'b0;
      vblankR <= 1'b0;
      palR <= 1'b0;
    end
    else if (edgeHit) // R17
    begin
      vsyncR <= fieldLine < `VAF_VSYNC_LINES;
      fieldR <= field;
      vblankR <= vbWin; // R21
      palR <= ~palR;
    end
  end

  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pixelOut <= 8'h00;
      vsyncOut <= 1'b0;
      hsyncOut <= 1'b0;
      activeVideoIndicator <= 1'b0;
      fieldOrVlockPin <= 1'b0;
      gpOrVblankPin <= 1'b0;
      palOrHlockPin <= 1'b0;
    end
    else
    begin
      pixelOut <= next_pixelOut;
      vsyncOut <= vsyncR; // R16
      hsyncOut <= pix < `VAF_HSYNC_LEN;
      activeVideoIndicator <= avidOn; // R19 R20
      fieldOrVlockPin <= pcfg.ctrl[`VAF_CTRL_SEL3] ? verticalLockIndicator : fieldR; // R16
      gpOrVblankPin <= pcfg.ctrl[`VAF_CTRL_SEL4] ? vblankR : pcfg.ctrl[`VAF_CTRL_GPVAL];
      palOrHlockPin <= pcfg.ctrl[`VAF_CTRL_SEL5] ? horizontalLockIndicator : palR;
    end
  end

endmodule : vaf_formatter
`default_nettype wire

/* File: hw/vaf_pkg.sv */
`default_nettype none
package vaf_pkg;
  typedef struct packed {
    logic [9:0] lineNum;
    logic field;
    logic [3:0] lineMode;
    logic match1;
    logic match2;
    logic edcError;
    logic [7:0] syncPattern;
  } vaf_slice_info_s;
  typedef struct packed {
    logic [9:0] cropStart;
    logic [9:0] cropStop;
    logic [7:0] vbStart;
    logic [7:0] vbStop;
    logic [9:0] syncEdge;
    logic [7:0] ctrl;
  } vaf_cfg_s;
  typedef enum logic [3:0] {
    B_IDLE = 4'h1,
    B_DATA = 4'h2,
    B_COPY = 4'h4,
    B_WAIT = 4'h8
  } vaf_build_e;
endpackage : vaf_pkg
`default_nettype wire

/* File: test/vaf_formatter_props.sv */
`include "vaf_defines.svh"
`default_nettype none
module vaf_formatter_props
  import vaf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic sclk,
  input wire logic [7:0] pixelOut
);
  logic [7:0] sh12;
  logic [7:0] sh14;
  logic [7:0] sh19;
  // shadows assume no write and read of one address in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh12 <= `VAF_RST_CROP_START_LO;
      sh14 <= `VAF_RST_CROP_STOP_LO;
      sh19 <= `VAF_RST_VB_STOP;
    end
    else if (regWrite)
    begin
      if (regAddr == 8'h12) sh12 <= regWrData;
      if (regAddr == 8'h14) sh14 <= regWrData;
      if (regAddr == 8'h19) sh19 <= regWrData;
    end
  end
  sequence pre_s;
    pixelOut == 8'h00 ##1 pixelOut == 8'hff ##1 pixelOut == 8'hff;
  endsequence
  sequence par_s;
    pixelOut[6] == ^pixelOut[5:0] && pixelOut[7] != pixelOut[6];
  endsequence
  sequence eav_s;
    pixelOut == 8'hff ##1 pixelOut == 8'h00 ##1 pixelOut == 8'h00;
  endsequence
  chk_start_lo_read: assert property (@(posedge clk) disable iff (!rst_n)
    regRead && regAddr == 8'h12 |=> regRdData == sh12) else $error("start low read wrong");
  chk_stop_lo_read: assert property (@(posedge clk) disable iff (!rst_n)
    regRead && regAddr == 8'h14 |=> regRdData == sh14) else $error("stop low read wrong");
  chk_vb_stop_read: assert property (@(posedge clk) disable iff (!rst_n)
    regRead && regAddr == 8'h19 |=> regRdData == sh19) else $error("vblank stop read wrong");
  chk_fifo_level_max: assert property (@(posedge clk) disable iff (!rst_n)
    regRead && regAddr == 8'h1e |=> regRdData[7:2] == 6'h00 && regRdData[1:0] != 2'h3)
    else $error("fifo level above depth");
  chk_pkt_type_id: assert property (@(posedge sclk) disable iff (!rst_n)
    pre_s |=> pixelOut[5:3] == 3'b010 && pixelOut inside {8'h91, 8'h55, 8'h53, 8'h97})
    else $error("bad packet type id");
  chk_id_parity: assert property (@(posedge sclk) disable iff (!rst_n)
    pre_s |=> ##1 par_s ##1 par_s) else $error("bad id parity");
  chk_pkt_after_eav: assert property (@(posedge sclk) disable iff (!rst_n)
    pre_s |-> $past(pixelOut, 7) == 8'hff) else $error("packet not right after eav");
  chk_code_status: assert property (@(posedge sclk) disable iff (!rst_n)
    eav_s |=> pixelOut[7] && pixelOut[3:0] == {pixelOut[5] ^ pixelOut[4],
      pixelOut[6] ^ pixelOut[4], pixelOut[6] ^ pixelOut[5], ^pixelOut[6:4]})
    else $error("bad timing code status");
  cov_packet: cover property (@(posedge sclk) disable iff (!rst_n) pre_s);
  cov_code: cover property (@(posedge sclk) disable iff (!rst_n) eav_s);
  cov_fifo_pop: cover property (@(posedge clk) disable iff (!rst_n) regRead && regAddr == 8'hb0);
endmodule : vaf_formatter_props
bind vaf_formatter vaf_formatter_props vaf_formatter_props_i (.clk(clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .sclk(sclk), .pixelOut(pixelOut));
`default_nettype wire

/* File: test/vaf_formatter_tb_top.sv */
`include "vaf_defines.svh"
`default_nettype none
module vaf_formatter_tb_top
  import vaf_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sclk, rst_n, regWrite, regRead, sliceStart, sliceValid, sliceEnd;
  logic [7:0] regAddr, regWrData, regRdData, sliceByte, pixelOut, rdv;
  vaf_slice_info_s sliceInfo;
  logic vsyncOut, hsyncOut, activeVideoIndicator, fieldPin, gpPin, palPin;
  logic [7:0] pkt [0:63];
  logic [7:0] expQ [$];
  int pktCount, lineLen, avLen;
  int err_count = 0;
  int check_count = 0;
  vaf_formatter vaf_formatter_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sliceStart(sliceStart), .sliceInfo(sliceInfo), .sliceValid(sliceValid),
    .sliceByte(sliceByte), .sliceEnd(sliceEnd), .sclk(sclk), .videoIn(8'h55),
    .adSample(8'h66), .verticalLockIndicator(1'b1), .horizontalLockIndicator(1'b0),
    .pixelOut(pixelOut), .vsyncOut(vsyncOut), .hsyncOut(hsyncOut),
    .activeVideoIndicator(activeVideoIndicator), .fieldOrVlockPin(fieldPin),
    .gpOrVblankPin(gpPin), .palOrHlockPin(palPin));
  vaf_pixel_sink vaf_pixel_sink_i (.sclk(sclk), .rst_n(rst_n), .pixelOut(pixelOut),
    .hsyncOut(hsyncOut), .activeVideoIndicator(activeVideoIndicator),
    .pktCount(pktCount), .pkt(pkt), .lineLen(lineLen), .avLen(avLen));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // offset keeps most link edges off the register clock edges; the two still meet every 800 ns, first at 775 ns
  initial
  begin
    sclk = 1'b0;
    #7;
    forever #32 sclk = ~sclk;
  end
  task summarize;
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] pb(input logic [5:0] v);
    return {~^v, ^v, v};
  endfunction : pb
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd
  task t_regs;
    logic [7:0] ad [6] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h18, 8'h19};
    logic [7:0] rv [6] = '{`VAF_RST_CROP_START_HI, `VAF_RST_CROP_START_LO,
      `VAF_RST_CROP_STOP_HI, `VAF_RST_CROP_STOP_LO, `VAF_RST_VB_START, `VAF_RST_VB_STOP};
    foreach (ad[k])
    begin
      rd(ad[k]);
      chk(rdv, rv[k]);
      wr(ad[k], 8'h01);
      rd(ad[k]);
      chk(rdv, 8'h01);
      wr(ad[k], rv[k]);
    end
    wr(8'h77, 8'h5a);
    rd(8'h77);
    chk(rdv, 8'h00);
  endtask : t_regs
  // fl is {edc error, match 1, match 2}
  task automatic t_pkt(input logic [9:0] ln, input logic f, input logic [3:0] m,
    input logic [2:0] fl, input int np, input logic ok);
    logic [7:0] pay [$];
    logic [7:0] packet_type_id;
    logic [7:0] s;
    int c, t, n;
    for (int k = 0; k < np; k++) pay.push_back(8'h30 + 8'(k));
    @(posedge clk);
    sliceStart <= 1'b1;
    sliceInfo <= '{ln, f, m, fl[1], fl[0], fl[2], 8'h27};
    @(posedge clk);
    sliceStart <= 1'b0;
    foreach (pay[k])
    begin
      sliceValid <= 1'b1;
      sliceByte <= pay[k];
      @(posedge clk);
    end
    sliceValid <= 1'b0;
    sliceEnd <= 1'b1;
    @(posedge clk);
    sliceEnd <= 1'b0;
    if (m <= 4'h5) pay.push_front(8'h27);
    n = (pay.size() + 4) / 4;
    packet_type_id = f ? `VAF_DID_F2_VBI : `VAF_DID_F1_VBI;
    if (ln >= `VAF_LATE_LINE) packet_type_id = f ? `VAF_DID_F2_LATE : `VAF_DID_F1_LATE;
    expQ = '{8'h00, 8'hff, 8'hff, packet_type_id, pb({2'b00, m}), pb(n[5:0]), ln[7:0], {3'b000, fl, ln[9:8]}};
    expQ = {expQ, pay};
    s = 8'h00;
    for (int k = 3; k < expQ.size(); k++) s += expQ[k];
    expQ.push_back(pb(s[5:0]));
    while (expQ.size() % 4 != 0) expQ.push_back(`VAF_FILL);
    c = pktCount;
    for (t = 0; t < 8000 && pktCount == c; t++) @(posedge clk);
    if (ok)
    begin
      if (t == 8000)
      begin
        err_count++;
        summarize();
      end
      for (int k = 3; k < expQ.size(); k++)
        chk(pkt[k], expQ[k]);
    end
    else
      chk(pktCount, c);
    rd(8'h1d);
    chk(rdv, ok ? expQ.size() : 0);
    rd(8'h1e);
    chk(rdv, 8'h00);
    for (int k = 0; ok && k < expQ.size(); k++)
    begin
      rd(8'hb0);
      chk(rdv, expQ[k]);
    end
  endtask : t_pkt
  task t_av(input logic [7:0] ctl, input logic [9:0] st, input logic [9:0] sp, input int el,
    input int ea);
    int t;
    wr(8'h19, 8'h00);
    wr(8'h1a, ctl);
    wr(8'h11, {6'h00, st[9:8]});
    wr(8'h12, st[7:0]);
    wr(8'h13, {6'h00, sp[9:8]});
    wr(8'h14, sp[7:0]);
    // three lines: config crossing plus one whole measured line
    repeat (2600) @(posedge sclk);
    chk(lineLen, el);
    chk(avLen, ea);
    // line start first, so the check lands just after the indicator rises
    for (t = 0; t < 1000 && !hsyncOut; t++) @(posedge sclk);
    for (; t < 2000 && !activeVideoIndicator; t++) @(posedge sclk);
    if (t == 2000)
    begin
      err_count++;
      summarize();
    end
    repeat (8) @(posedge sclk);
    #1 chk(pixelOut, ctl[`VAF_CTRL_RAW] ? 8'h66 : 8'h55);
    if (ctl[`VAF_CTRL_SEL3])
      chk({fieldPin, gpPin, palPin}, 3'b110);
  endtask : t_av
  initial
  begin
    {regWrite, regRead, sliceStart, sliceValid, sliceEnd} = '0;
    {regAddr, regWrData, sliceByte} = '0;
    sliceInfo = '0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pkt(10'd6, 1'b0, 4'h3, 3'b010, 3, 1'b1);
    t_pkt(10'd10, 1'b1, 4'h7, 3'b000, 2, 1'b1);
    t_pkt(10'd25, 1'b1, 4'h4, 3'b101, 5, 1'b1);
    t_pkt(10'd27, 1'b0, 4'h9, 3'b001, 4, 1'b1);
    t_pkt(10'd5, 1'b0, 4'h7, 3'b000, 2, 1'b0);
    t_pkt(10'd28, 1'b1, 4'h7, 3'b000, 2, 1'b0);
    t_av(8'h81, 10'd138, 10'd858, 858, 724);
    t_av(8'h80, 10'd138, 10'd858, 858, 720);
    t_av(8'h80, 10'd200, 10'd600, 858, 400);
    t_av(8'h85, 10'd200, 10'd600, 864, 404);
    t_av(8'hea, 10'd138, 10'd858, 858, 720);
    summarize();
  end
endmodule : vaf_formatter_tb_top
`default_nettype wire

/* File: test/vaf_pixel_sink.sv */
`default_nettype none
module vaf_pixel_sink
  import vaf_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic [7:0] pixelOut,
  input wire logic hsyncOut,
  input wire logic activeVideoIndicator,
  output var int pktCount,
  output var logic [7:0] pkt [0:63],
  output var int lineLen,
  output var int avLen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] p1, p2;
  logic hs, av;
  int idx, want, lc, ac;
  always @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {p1, p2, hs, av} <= '0;
      {idx, want, lc, ac, pktCount, lineLen, avLen} <= '0;
    end
    else
    begin
      p1 <= pixelOut;
      p2 <= p1;
      hs <= hsyncOut;
      av <= activeVideoIndicator;
      lc <= (hsyncOut && !hs) ? 1 : lc + 1;
      if (hsyncOut && !hs) lineLen <= lc;
      ac <= activeVideoIndicator ? ac + 1 : 0;
      if (!activeVideoIndicator && av) avLen <= ac;
      if (idx == 0 && p2 == 8'h00 && p1 == 8'hff && pixelOut == 8'hff)
        idx <= 3;
      else if (idx > 0)
      begin
        pkt[idx] <= pixelOut;
        idx <= idx + 1;
        // length taken from the count byte, so a wrong count shows as wrong bytes
        if (idx == 5) want <= 8 + 4 * pixelOut[5:0];
        if ((idx > 5 && idx + 1 == want) || idx == 63)
        begin
          idx <= 0;
          pktCount <= pktCount + 1;
        end
      end
    end
  end
endmodule : vaf_pixel_sink
`default_nettype wire
